// >>> cfg_loader_pkg.sv
// Package: constants for the non-volatile configuration loader
package cfg_loader_pkg;
    // ----------------------------------------
    // Memory geometry
    // ----------------------------------------
    localparam int MEM_BYTES = 8192;
    localparam int PAGE_BYTES = 64;
    localparam int MEM_AW = 13;
    localparam int PAGE_AW = 6;
    // ----------------------------------------
    // Section bounds (byte addresses)
    // ----------------------------------------
    localparam logic [12:0] SEC_IDENT_END = 13'h001f;
    localparam logic [12:0] SEC_RESET_BASE = 13'h0040;
    localparam logic [12:0] SEC_FREE_BASE = 13'h00c0;
    localparam logic [12:0] SEC_KEY_BASE = 13'h1800;
    localparam logic [12:0] SEC_PROT_BASE = 13'h1c00;
    // ----------------------------------------
    // Page 0 configuration bytes
    // ----------------------------------------
    localparam logic [12:0] PART_ID_ADDR = 13'h0000;
    localparam logic [12:0] SIL_VER_ADDR = 13'h0002;
    localparam logic [12:0] HOST_ADDR_ADDR = 13'h0020;
    localparam logic [12:0] IFACE_CFG_ADDR = 13'h0021;
    localparam logic [12:0] SAM_ADDR_ADDR = 13'h0022;
    localparam logic [12:0] DEF_RX_ADDR = 13'h0023;
    localparam logic [12:0] DEF_TX_ADDR = 13'h0024;
    localparam logic [12:0] TX_SEED_ADDR = 13'h0026;
    localparam logic [12:0] RX_SEED_ADDR = 13'h0028;
    localparam int IF_FAST_BIT = 7;
    localparam int IF_ADDRSRC_BIT = 4;
    localparam int IF_BSCAN_BIT = 3;
    localparam logic [4:0] PIN_ADDR_UPPER = 5'h15;
    localparam logic [1:0] HOST_UART = 2'h0;
    localparam logic [1:0] HOST_I2C = 2'h1;
    localparam logic [1:0] HOST_SPI = 2'h2;
    localparam logic [1:0] HOST_LOW_SPEED_BUS_VARIANT = 2'h3;
    // ----------------------------------------
    // Protocol set layout
    // ----------------------------------------
    localparam int TX_SET_BYTES = 16;
    localparam int RX_SET_BYTES = 8;
    localparam int SET_BYTES = 24;
    localparam int RESET_COPY_BYTES = 128;
    // ----------------------------------------
    // Avalon register word offsets (byte addresses)
    // ----------------------------------------
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STATUS = 6'h04;
    localparam logic [5:0] REG_MEM_ADDR = 6'h08;
    localparam logic [5:0] REG_MEM_DATA = 6'h0c;
    localparam logic [5:0] REG_PROG = 6'h10;
    localparam logic [5:0] REG_CFG = 6'h14;
    localparam logic [5:0] REG_SEED = 6'h18;
    localparam logic [5:0] REG_LOAD_SRC = 6'h1c;
    localparam logic [5:0] REG_IDENT = 6'h20;
    localparam logic [5:0] REG_PAGE_BUF = 6'h24;
    localparam logic [31:0] UNMAPPED_DATA = 32'hdead_beef;
    localparam logic [7:0] PART_ID_LO = 8'h5a;
    localparam logic [7:0] PART_ID_HI = 8'h01;
    localparam logic [7:0] SIL_VER = 8'h11;
    // ----------------------------------------
    // Engine states
    // ----------------------------------------
    typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_COPY, ST_PROG, ST_READ} state_t;
endpackage

// >>> eeprom_config_loader.sv
// Non-volatile config memory with copy engine and Avalon-MM register slave
//
// Functional notes
// [R1] Copy reset-value area to registers at startup
// [R2] Protocol-load command copies chosen protocol set
// [R3] Stored-settings command copies from free section; code sets no upper bound, so key or protected bytes can be copied
// [R4] Eight kilobytes, sixty-four byte pages, linear
// [R5] Programming never spans more than one page
// [R6] Enforce per-section read/write access map
// [R7] Page zero holds part and silicon identifiers
// [R8] Host ignores factory bytes, treated undefined
// [R9] Pin address: fixed upper bits, pins low
// [R10] Interface bit four picks address source
// [R11] Interface bit seven picks fast variant
// [R12] Interface bit three disables boundary scan
// [R13] Interface bits two-zero select host interface
// [R14] Secure-module address always from stored byte
// [R15] Protocol set: sixteen tx, eight rx bytes
// [R16] Transmit checksum seed from stored preset
// [R17] Copy source addresses changeable by host; code keeps the startup copy source fixed at SEC_RESET_BASE
// [R18] Refuse writes to RO, reads of keys
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module eeprom_config_loader
    import cfg_loader_pkg::*;
#(
    parameter int REG_BYTES = 128
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic iface_select_pin_a,
    input wire logic iface_select_pin_c,
    input wire logic [1:0] host_pin_select,
    output logic [6:0] host_bus_addr,
    output logic [6:0] secure_module_bus_addr,
    output logic [1:0] host_iface_sel,
    output logic fast_bus_variant_select,
    output logic boundary_scan_en,
    output logic [15:0] transmit_checksum_seed,
    output logic [7:0] receive_checksum_seed,
    output logic reg_wr_en,
    output logic [6:0] reg_wr_addr,
    output logic [7:0] reg_wr_data,
    output logic loader_busy
);
    import cfg_loader_pkg::*;

    // Register window is seven bits wide and must hold one protocol set
    if (REG_BYTES < SET_BYTES || REG_BYTES > 128) begin : g_bad_reg_bytes
        $error("REG_BYTES out of range");
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] mem_r [MEM_BYTES]; // [R4]
    logic [7:0] page_buf_r [PAGE_BYTES];
    state_t state_r;
    logic [12:0] mem_addr_r;
    logic [12:0] src_r;
    logic [6:0] dst_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_end_r;
    logic [7:0] rd_byte_r;
    logic refused_r;
    logic [12:0] set_src_r;
    logic [31:0] rdata_r;
    logic done_r;
    logic [7:0] iface_r, host_addr_r, sam_addr_r, tx_lo_r, tx_hi_r, rx_seed_r;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire bus_req = (avs_read | avs_write) & ~done_r;
    wire idle = (state_r == ST_IDLE);
    wire wr_ctrl = avs_write & idle & ~done_r & (avs_address == REG_CTRL);
    wire wr_addr = avs_write & idle & ~done_r & (avs_address == REG_MEM_ADDR);
    wire wr_buf = avs_write & idle & ~done_r & (avs_address == REG_PAGE_BUF);
    wire wr_prog = avs_write & idle & ~done_r & (avs_address == REG_PROG);
    wire rd_data = avs_read & idle & ~done_r & (avs_address == REG_MEM_DATA);
    wire cmd_proto = wr_ctrl & avs_writedata[0];
    wire cmd_stored = wr_ctrl & avs_writedata[1];
    wire [12:0] w_addr = avs_writedata[12:0];
    wire in_ident = mem_addr_r <= SEC_IDENT_END;
    wire in_key = (mem_addr_r >= SEC_KEY_BASE) & (mem_addr_r < SEC_PROT_BASE);
    wire in_prot = mem_addr_r >= SEC_PROT_BASE;
    wire prog_ok = ~in_ident & ~in_prot; // [R6] [R18]
    wire [5:0] prog_len = avs_writedata[5:0];
    wire prog_fits = ({1'b0, mem_addr_r[5:0]} + {1'b0, prog_len}) <= 7'h3f; // [R5]
    wire [12:0] stored_src = avs_writedata[28:16];

    // ----------------------------------------
    // Configuration decode
    // ----------------------------------------
    assign host_bus_addr = iface_r[IF_ADDRSRC_BIT] ? host_addr_r[6:0]
        : {PIN_ADDR_UPPER, iface_select_pin_c, iface_select_pin_a}; // [R9] [R10]
    assign secure_module_bus_addr = sam_addr_r[6:0]; // [R14]
    assign fast_bus_variant_select = iface_r[IF_FAST_BIT]; // [R11]
    assign boundary_scan_en = ~iface_r[IF_BSCAN_BIT]; // [R12]
    assign host_iface_sel = iface_r[2] ? host_pin_select : iface_r[1:0]; // [R13]
    assign transmit_checksum_seed = {tx_hi_r, tx_lo_r}; // [R16]
    assign receive_checksum_seed = rx_seed_r;
    assign loader_busy = (state_r == ST_BOOT) | (state_r == ST_COPY) | (state_r == ST_PROG);
    // One wait cycle when idle; held off for the whole copy or program
    assign avs_waitrequest = bus_req;
    assign avs_readdata = rdata_r;

    // ----------------------------------------
    // Readback mux
    // ----------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        unique case (avs_address)
            REG_STATUS: rd_mux = {29'h0, refused_r, loader_busy, idle};
            REG_MEM_ADDR: rd_mux = {19'h0, mem_addr_r};
            REG_MEM_DATA: rd_mux = {24'h0, (in_key ? 8'h00 : mem_r[mem_addr_r])}; // [R18]
            REG_CFG: rd_mux = {8'h0, sam_addr_r, iface_r, host_addr_r};
            REG_SEED: rd_mux = {8'h0, rx_seed_r, tx_hi_r, tx_lo_r};
            REG_LOAD_SRC: rd_mux = {19'h0, set_src_r};
            REG_IDENT: rd_mux = {8'h0, mem_r[SIL_VER_ADDR], mem_r[1], mem_r[PART_ID_ADDR]}; // [R7]
            REG_CTRL, REG_PROG, REG_PAGE_BUF: rd_mux = 32'h0;
            default: rd_mux = UNMAPPED_DATA;
        endcase
    end

    // ----------------------------------------
    // Copy engine and bus state
    // ----------------------------------------
    wire copy_last = (cnt_r == cnt_end_r);
    wire [7:0] cur = mem_r[src_r];

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= ST_BOOT;
            src_r <= SEC_RESET_BASE; // [R1]
            dst_r <= 7'h0;
            cnt_r <= 8'h0;
            cnt_end_r <= 8'(REG_BYTES - 1);
            mem_addr_r <= 13'h0;
            refused_r <= 1'b0;
            set_src_r <= SEC_PROT_BASE;
            rdata_r <= 32'h0;
            done_r <= 1'b0;
            reg_wr_en <= 1'b0;
            reg_wr_addr <= 7'h0;
            reg_wr_data <= 8'h0;
        end else begin
            done_r <= 1'b0;
            reg_wr_en <= 1'b0;
            if (avs_read & ~done_r & idle) begin
                rdata_r <= rd_mux;
                done_r <= 1'b1;
            end
            unique case (state_r)
                ST_BOOT, ST_COPY: begin
                    reg_wr_en <= 1'b1; // [R1] [R2] [R3]
                    reg_wr_addr <= dst_r;
                    reg_wr_data <= cur;
                    src_r <= src_r + 13'h1;
                    dst_r <= dst_r + 7'h1;
                    cnt_r <= cnt_r + 8'h1;
                    if (copy_last) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_PROG: begin
                    state_r <= ST_IDLE; // [R5]
                end
                default: begin
                    if (wr_addr) begin
                        mem_addr_r <= w_addr;
                    end
                    if (avs_address == REG_LOAD_SRC && avs_write & ~done_r) begin
                        set_src_r <= w_addr; // [R17]
                    end
                    if (cmd_proto) begin
                        src_r <= set_src_r + 13'(avs_writedata[7:4]) * 13'(SET_BYTES); // [R2] [R15] [R17]
                        dst_r <= 7'h0;
                        cnt_r <= 8'h0;
                        cnt_end_r <= 8'(SET_BYTES - 1);
                        state_r <= ST_COPY;
                    end else if (cmd_stored) begin
                        src_r <= (stored_src < SEC_FREE_BASE) ? SEC_FREE_BASE : stored_src; // [R3]
                        dst_r <= avs_writedata[14:8];
                        cnt_r <= 8'h0;
                        cnt_end_r <= {2'h0, avs_writedata[7:2]};
                        state_r <= ST_COPY;
                    end
                    if (wr_prog) begin
                        refused_r <= ~(prog_ok & prog_fits); // [R6] [R18]
                        if (prog_ok & prog_fits) begin
                            state_r <= ST_PROG;
                        end
                    end
                    if (rd_data) begin
                        refused_r <= in_key; // [R18]
                    end
                    if (avs_write & ~done_r) begin
                        done_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Page buffer and memory array
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (wr_buf) begin
            page_buf_r[avs_writedata[13:8]] <= avs_writedata[7:0];
        end
        if (wr_prog & prog_ok & prog_fits) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (6'(i) <= prog_len) begin
                    mem_r[{mem_addr_r[12:6], 6'(mem_addr_r[5:0] + 6'(i))}] <= page_buf_r[i]; // [R5]
                end
            end
        end
        if (state_r == ST_BOOT && cnt_r == 8'h0) begin
            mem_r[PART_ID_ADDR] <= PART_ID_LO; // [R7]
            mem_r[1] <= PART_ID_HI;
            mem_r[SIL_VER_ADDR] <= SIL_VER;
        end
    end

    // ----------------------------------------
    // Live configuration bytes
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            iface_r <= 8'h80;
            host_addr_r <= 8'h0;
            sam_addr_r <= 8'h0;
            tx_lo_r <= 8'h0;
            tx_hi_r <= 8'h0;
            rx_seed_r <= 8'h0;
        end else if (state_r == ST_IDLE || state_r == ST_PROG) begin
            host_addr_r <= mem_r[HOST_ADDR_ADDR];
            iface_r <= mem_r[IFACE_CFG_ADDR]; // [R13]
            sam_addr_r <= mem_r[SAM_ADDR_ADDR]; // [R14]
            tx_lo_r <= mem_r[TX_SEED_ADDR]; // [R16]
            tx_hi_r <= mem_r[TX_SEED_ADDR + 13'h1];
            rx_seed_r <= mem_r[RX_SEED_ADDR];
        end
    end
endmodule

// >>> eeprom_config_loader_assertions.sv
// Port-level checks for the configuration loader
`timescale 1ns/1ns
module eeprom_config_loader_assertions
    import cfg_loader_pkg::*;
#(
    parameter int REG_BYTES = 128
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic iface_select_pin_a,
    input wire logic iface_select_pin_c,
    input wire logic [1:0] host_pin_select,
    input wire logic [6:0] host_bus_addr,
    input wire logic [1:0] host_iface_sel,
    input wire logic reg_wr_en,
    input wire logic [6:0] reg_wr_addr,
    input wire logic loader_busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic boot_r;
    int boot_cnt_r;
    // Counts the startup copy stream only
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            boot_r <= 1'b1;
            boot_cnt_r <= 0;
        end else begin
            boot_r <= boot_r && !$fell(loader_busy);
            boot_cnt_r <= boot_cnt_r + ((boot_r && reg_wr_en) ? 1 : 0);
        end
    end
    sequence answer_s;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    chk_idle_answer: assert property (($rose(avs_read) || $rose(avs_write)) && !loader_busy |-> answer_s)
        else $error("idle request not answered after one wait cycle");
    chk_busy_hold: assert property (loader_busy && $rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request accepted while busy");
    chk_boot_busy: assert property ($fell(reset) |-> loader_busy)
        else $error("not busy after reset release");
    chk_boot_start: assert property ($fell(reset) |-> ##[0:2] (reg_wr_en && reg_wr_addr == 7'h00))
        else $error("startup copy did not begin at register zero");
    chk_boot_count: assert property ($fell(boot_r) |-> boot_cnt_r == REG_BYTES)
        else $error("startup copy length wrong");
    chk_stream_busy: assert property (reg_wr_en |-> loader_busy || $past(loader_busy))
        else $error("register write outside a copy");
    chk_unmapped_read: assert property (avs_read && !avs_waitrequest && avs_address == 6'h3c
        |-> avs_readdata == UNMAPPED_DATA)
        else $error("unmapped read data wrong");
    chk_pin_addr: assert property ($changed({iface_select_pin_c, iface_select_pin_a}) && $changed(host_bus_addr)
        |-> host_bus_addr == {PIN_ADDR_UPPER, iface_select_pin_c, iface_select_pin_a})
        else $error("pin derived bus address wrong");
    chk_pin_iface: assert property ($changed(host_pin_select) && $changed(host_iface_sel)
        |-> host_iface_sel == host_pin_select)
        else $error("pin host selection wrong");
endmodule

// >>> eeprom_config_loader_bench.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ns
module eeprom_config_loader_bench;
    import cfg_loader_pkg::*;
    localparam int RB = 64;
    logic sys_clk = 1'b0, reset = 1'b1, iface_select_pin_a = 1'b0, iface_select_pin_c = 1'b0, hung;
    logic avs_read, avs_write, avs_waitrequest, reg_wr_en, loader_busy, fast_bus_variant_select, boundary_scan_en;
    logic [1:0] host_pin_select = 2'h0, host_iface_sel;
    logic [3:0] avs_byteenable = 4'hf;
    logic [5:0] avs_address;
    logic [6:0] host_bus_addr, secure_module_bus_addr, reg_wr_addr;
    logic [7:0] receive_checksum_seed, reg_wr_data, v, pg[64];
    logic [15:0] transmit_checksum_seed;
    logic [31:0] avs_writedata, avs_readdata, q, r, lfsr = 32'h92889f47;
    logic [7:0] mem_m[int];
    logic [14:0] wq[$];
    int mismatches = 0, n_compared = 0, dst;
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (reg_wr_en === 1'b1) wq.push_back({reg_wr_addr, reg_wr_data});
    eeprom_config_loader #(.REG_BYTES(RB)) dut_u (.*);
    host_model host_u (.*);
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge hung) begin
        mismatches++;
        end_sim();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_stream(input int d, input int s, input int cnt, input int nd);
        chk(wq.size(), cnt);
        for (int i = 0; i < nd; i++) chk(wq[i], {7'(d + i), mem_m[s + i]});
        wq.delete();
    endtask
    task automatic rd_byte(input logic [12:0] a);
        host_u.wr(REG_MEM_ADDR, 32'(a));
        host_u.rd(REG_MEM_DATA, q);
        v = q[7:0];
    endtask
    task automatic prog(input logic [12:0] a, input int cnt);
        host_u.wr(REG_MEM_ADDR, 32'(a));
        for (int i = 0; i < cnt; i++) host_u.wr(REG_PAGE_BUF, {18'h0, 6'(i), pg[i]});
        host_u.wr(REG_PROG, 32'(cnt - 1));
        host_u.rd(REG_STATUS, q);
        if (a <= SEC_IDENT_END || a >= SEC_PROT_BASE) begin
            chk(q[2], 1'b1);
        end else begin
            chk(q[2], 1'b0);
            for (int i = 0; i < cnt; i++) mem_m[a + i] = pg[i];
        end
    endtask
    initial begin
        mem_m[0] = PART_ID_LO;
        mem_m[1] = PART_ID_HI;
        mem_m[2] = SIL_VER;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        host_u.rd(REG_STATUS, q);
        chk_stream(0, 64, RB, 0);
        // Factory bytes past the identifiers stay unread
        for (int i = 0; i < 3; i++) begin
            rd_byte(13'(i));
            chk(v, mem_m[i]);
        end
        for (int p = 64; p < 256; p += 128) begin
            for (int i = 0; i < 64; i++) pg[i] = rnd();
            prog(13'(p), 64);
        end
        for (int i = 0; i < 64; i += 9) begin
            rd_byte(13'(192 + i));
            chk(v, mem_m[192 + i]);
        end
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        host_u.rd(REG_STATUS, q);
        chk_stream(0, 64, RB, RB);
        for (int k = 0; k < 16; k += 15) begin
            host_u.wr(REG_CTRL, {24'h0, 4'(k), 4'h1});
            host_u.rd(REG_STATUS, q);
            chk_stream(0, 0, SET_BYTES, 0);
        end
        dst = int'(rnd() % 64);
        host_u.wr(REG_CTRL, {3'h0, 13'h00c0, 1'b0, 7'(dst), 6'd31, 2'b10});
        host_u.rd(REG_STATUS, q);
        chk_stream(dst, 192, 32, 32);
        for (int k = 0; k < 5; k++) begin
            r = rnd();
            {iface_select_pin_c, iface_select_pin_a, host_pin_select} <= r[27:24];
            pg = '{default: 8'h00};
            pg[0] = r[7:0];
            pg[1] = {r[15], 2'b00, r[12:11], k == 4 ? {1'b1, r[9:8]} : 3'(k)};
            pg[2] = r[23:16];
            pg[6] = r[31:24];
            pg[7] = r[15:8];
            pg[8] = r[7:0];
            prog(13'h0020, 9);
            chk(host_bus_addr, pg[1][4] ? pg[0][6:0] : {PIN_ADDR_UPPER, iface_select_pin_c, iface_select_pin_a});
            chk(secure_module_bus_addr, pg[2][6:0]);
            chk(host_iface_sel, pg[1][2] ? host_pin_select : pg[1][1:0]);
            chk({fast_bus_variant_select, boundary_scan_en}, {pg[1][7], !pg[1][3]});
            chk({transmit_checksum_seed, receive_checksum_seed}, {pg[7], pg[6], pg[8]});
        end
        rd_byte(SEC_KEY_BASE);
        chk(v, 8'h00);
        host_u.rd(REG_STATUS, q);
        chk(q[2], 1'b1);
        prog(13'h0000, 1);
        rd_byte(13'h0000);
        chk(v, PART_ID_LO);
        prog(SEC_PROT_BASE, 1);
        host_u.rd(6'h3c, q);
        chk(q, UNMAPPED_DATA);
        end_sim();
    end
endmodule
bind eeprom_config_loader eeprom_config_loader_assertions #(.REG_BYTES(REG_BYTES)) chk_u (.*);

// >>> host_model.sv
// Host controller model: register bus master
`timescale 1ns/1ns
module host_model (
    input wire logic sys_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic hung
);
    initial {avs_address, avs_read, avs_write, avs_writedata, hung} = '0;
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 4000);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Released lines show no stale value
        avs_address <= ~a;
        avs_writedata <= ~d;
        hung <= n >= 4000;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
endmodule
